/* core/rot_cfg.svh */
`ifndef ROT_CFG_SVH
`define ROT_CFG_SVH
`define ROT_WIDTH 8
`define ROT_ADDR_WIDTH 8
`define ROT_TOP_BIT 7
`define ROT_MEM_RD_LATENCY 1
`endif

/* core/rot_pkg.sv */
package rot_pkg;
   typedef enum logic [2:0] {
      rotate_left_to_working = 3'h0,
      rotate_left_through_carry = 3'h1,
      rotate_left_through_carry_to_working = 3'h2,
      rotate_right_in_place = 3'h3,
      rotate_right_to_working = 3'h4,
      rotate_right_through_carry = 3'h5
   } rot_op_t;
endpackage

/* core/rot_shifter.sv */
`timescale 1ns/10ps
`include "rot_cfg.svh"
module rot_shifter (
   input wire logic [2:0] op,
   input wire logic [7:0] operand,
   input wire logic carry_in,
   output logic [7:0] result,
   output logic carry_out,
   output logic to_working,
   output logic uses_carry
);
   import rot_pkg::*;

   // one-place shifts; the caller supplies the bit that fills the vacated end
   function automatic logic [7:0] shl_in(input logic [7:0] v, input logic b);
      return {v[6:0], b};
   endfunction

   function automatic logic [7:0] shr_in(input logic [7:0] v, input logic b);
      return {b, v[7:1]};
   endfunction

   always_comb begin
      result = operand;
      carry_out = carry_in;
      to_working = 1'b0;
      uses_carry = 1'b0;
      case (rot_op_t'(op))
         rotate_left_to_working: begin
            result = shl_in(operand, operand[`ROT_TOP_BIT]);
            to_working = 1'b1;
         end
         rotate_left_through_carry: begin
            result = shl_in(operand, carry_in);
            carry_out = operand[`ROT_TOP_BIT];
            uses_carry = 1'b1;
         end
         rotate_left_through_carry_to_working: begin
            result = shl_in(operand, carry_in);
            carry_out = operand[`ROT_TOP_BIT];
            to_working = 1'b1;
            uses_carry = 1'b1;
         end
         rotate_right_in_place: begin
            result = shr_in(operand, operand[0]);
         end
         rotate_right_to_working: begin
            result = shr_in(operand, operand[0]);
            to_working = 1'b1;
         end
         rotate_right_through_carry: begin
            result = shr_in(operand, carry_in);
            carry_out = operand[0];
            uses_carry = 1'b1;
         end
         default: begin
            result = operand;
         end
      endcase
   end
endmodule

/* core/byte_rotate_unit.sv */
`timescale 1ns/10ps
`include "rot_cfg.svh"
module byte_rotate_unit (
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   input wire logic start,
   input wire rot_pkg::rot_op_t op,
   input wire logic [7:0] addr,
   input wire logic carry_in,
   input wire logic [7:0] mem_rdata,
   output logic mem_re,
   output logic mem_we,
   output logic [7:0] mem_addr,
   output logic [7:0] mem_wdata,
   output logic working_we,
   output logic [7:0] working_data,
   output logic carry_we,
   output logic carry_out,
   output logic busy,
   output logic done
);
   import rot_pkg::*;

   typedef enum logic [2:0] {
      st_idle = 3'h1,
      st_read = 3'h2,
      st_exec = 3'h4
   } st_t;

   st_t st_q, st_d;
   rot_op_t op_q, op_d;
   logic [7:0] addr_q, addr_d;
   logic cin_q, cin_d;
   logic mem_re_q, mem_re_d, mem_we_q, mem_we_d;
   logic [7:0] mem_wdata_q, mem_wdata_d;
   logic working_we_q, working_we_d;
   logic [7:0] working_data_q, working_data_d;
   logic carry_we_q, carry_we_d, carry_out_q, carry_out_d;
   logic done_q, done_d;
   logic busy_q, busy_d;
   logic [7:0] sh_result;
   logic sh_cout, sh_to_working, sh_uses_carry;

   rot_shifter u_shift (
      .op(op_q),
      .operand(mem_rdata),
      .carry_in(cin_q),
      .result(sh_result),
      .carry_out(sh_cout),
      .to_working(sh_to_working),
      .uses_carry(sh_uses_carry)
   );

   always_comb begin
      st_d = st_q;
      op_d = op_q;
      addr_d = addr_q;
      cin_d = cin_q;
      mem_re_d = 1'b0;
      mem_we_d = 1'b0;
      mem_wdata_d = mem_wdata_q;
      working_we_d = 1'b0;
      working_data_d = working_data_q;
      carry_we_d = 1'b0;
      carry_out_d = carry_out_q;
      done_d = 1'b0;
      case (st_q)
         st_idle: begin
            if (start) begin
               // operand address and carry are latched so the decoder may move on
               op_d = op;
               addr_d = addr;
               cin_d = carry_in;
               mem_re_d = 1'b1;
               st_d = st_read;
            end
         end
         st_read: begin
            // memory answers one cycle after the read strobe
            st_d = st_exec;
         end
         st_exec: begin
            if (sh_to_working) begin
               working_we_d = 1'b1;
               working_data_d = sh_result;
            end else begin
               mem_we_d = 1'b1;
               mem_wdata_d = sh_result;
            end
            if (sh_uses_carry) begin
               carry_we_d = 1'b1;
               carry_out_d = sh_cout;
            end
            done_d = 1'b1;
            st_d = st_idle;
         end
         default: begin
            st_d = st_idle;
         end
      endcase
      // busy leaves a flop too, so it settles together with done and the strobes
      busy_d = (st_d != st_idle);
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         st_q <= st_idle;
         op_q <= rotate_left_to_working;
         addr_q <= 8'h00;
         cin_q <= 1'b0;
         mem_re_q <= 1'b0;
         mem_we_q <= 1'b0;
         mem_wdata_q <= 8'h00;
         working_we_q <= 1'b0;
         working_data_q <= 8'h00;
         carry_we_q <= 1'b0;
         carry_out_q <= 1'b0;
         done_q <= 1'b0;
         busy_q <= 1'b0;
      end else if (ce) begin
         st_q <= st_d;
         op_q <= op_d;
         addr_q <= addr_d;
         cin_q <= cin_d;
         mem_re_q <= mem_re_d;
         mem_we_q <= mem_we_d;
         mem_wdata_q <= mem_wdata_d;
         working_we_q <= working_we_d;
         working_data_q <= working_data_d;
         carry_we_q <= carry_we_d;
         carry_out_q <= carry_out_d;
         done_q <= done_d;
         busy_q <= busy_d;
      end
   end

   assign mem_re = mem_re_q;
   assign mem_we = mem_we_q;
   assign mem_addr = addr_q;
   assign mem_wdata = mem_wdata_q;
   assign working_we = working_we_q;
   assign working_data = working_data_q;
   assign carry_we = carry_we_q;
   assign carry_out = carry_out_q;
   assign busy = busy_q;
   assign done = done_q;

   property p_wrap_left_working;
      @(posedge mclk) disable iff (rst)
      (ce && st_q == st_exec && op_q == rotate_left_to_working) |=>
      (working_we && !mem_we && !carry_we
       && working_data == {$past(mem_rdata[6:0]), $past(mem_rdata[7])});
   endproperty
   a_wrap_left_working: assert property (p_wrap_left_working) else $error("left wrap to working wrong");

   property p_left_carry_mem;
      @(posedge mclk) disable iff (rst)
      (ce && st_q == st_exec && op_q == rotate_left_through_carry) |=>
      (mem_we && carry_we && mem_wdata == {$past(mem_rdata[6:0]), $past(cin_q)}
       && carry_out == $past(mem_rdata[7]));
   endproperty
   a_left_carry_mem: assert property (p_left_carry_mem) else $error("left carry to memory wrong");

   property p_left_carry_working;
      @(posedge mclk) disable iff (rst)
      (ce && st_q == st_exec && op_q == rotate_left_through_carry_to_working) |=>
      (working_we && !mem_we && carry_we && carry_out == $past(mem_rdata[7])
       && working_data == {$past(mem_rdata[6:0]), $past(cin_q)});
   endproperty
   a_left_carry_working: assert property (p_left_carry_working) else $error("left carry to working wrong");

   property p_wrap_right_mem;
      @(posedge mclk) disable iff (rst)
      (ce && st_q == st_exec && op_q == rotate_right_in_place) |=>
      (mem_we && !carry_we && mem_wdata == {$past(mem_rdata[0]), $past(mem_rdata[7:1])});
   endproperty
   a_wrap_right_mem: assert property (p_wrap_right_mem) else $error("right wrap in place wrong");

   property p_wrap_right_working;
      @(posedge mclk) disable iff (rst)
      (ce && st_q == st_exec && op_q == rotate_right_to_working) |=>
      (working_we && !mem_we && !carry_we
       && working_data == {$past(mem_rdata[0]), $past(mem_rdata[7:1])});
   endproperty
   a_wrap_right_working: assert property (p_wrap_right_working) else $error("right wrap to working wrong");

   property p_right_carry_mem;
      @(posedge mclk) disable iff (rst)
      (ce && st_q == st_exec && op_q == rotate_right_through_carry) |=>
      (mem_we && carry_we && mem_wdata == {$past(cin_q), $past(mem_rdata[7:1])}
       && carry_out == $past(mem_rdata[0]));
   endproperty
   a_right_carry_mem: assert property (p_right_carry_mem) else $error("right carry in place wrong");

   property p_single_op;
      @(posedge mclk) disable iff (rst)
      (ce && st_q == st_idle && start) |=> (mem_re && busy && mem_addr == $past(addr));
   endproperty
   a_single_op: assert property (p_single_op) else $error("read strobe or address wrong");

   // done counts enabled cycles only; a frozen cycle simply stretches the operation
   property p_done_time;
      @(posedge mclk) disable iff (rst)
      (ce && st_q == st_idle && start) ##1 ce ##1 ce |=> (done && !busy);
   endproperty
   a_done_time: assert property (p_done_time) else $error("rotate did not finish in time");

   property p_freeze;
      @(posedge mclk) disable iff (rst)
      !ce |=> ($stable(st_q) && $stable(busy) && $stable(done) && $stable(mem_re)
       && $stable(mem_we) && $stable(working_we) && $stable(carry_we)
       && $stable(mem_wdata) && $stable(working_data) && $stable(carry_out));
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved while enable low");

   property p_one_write;
      @(posedge mclk) disable iff (rst)
      !(mem_we && working_we);
   endproperty
   a_one_write: assert property (p_one_write) else $error("both destinations written");
endmodule

/* tb/rot_mem.sv */
`timescale 1ns/10ps
module rot_mem (
   input wire logic mclk,
   input wire logic ce,
   input wire logic mem_re,
   input wire logic mem_we,
   input wire logic [7:0] mem_addr,
   input wire logic [7:0] mem_wdata,
   output logic [7:0] mem_rdata
);
   logic [7:0] mem [256];
   initial begin
      for (int i = 0; i < 256; i++) begin
         mem[i] = 8'(i * 8'h4D + 8'h0D);
      end
      mem_rdata = 8'h00;
   end
   // read data is valid for one enabled cycle only; then the bus toggles so stale data never passes
   // the memory shares the core enable, so read data waits out a frozen cycle
   always @(posedge mclk) begin
      if (ce) begin
         if (mem_re)
            mem_rdata <= mem[mem_addr];
         else
            mem_rdata <= ~mem_rdata;
         if (mem_we)
            mem[mem_addr] <= mem_wdata;
      end
   end
endmodule

/* tb/test_byte_rotate_unit.sv */
`timescale 1ns/10ps
module test_byte_rotate_unit;
   import rot_pkg::*;
   logic mclk = 1'b0, rst = 1'b1, ce = 1'b1, start = 1'b0, carry_in = 1'b0;
   rot_op_t op = rotate_left_to_working;
   logic [7:0] addr = 8'h00, mem_rdata, mem_addr, mem_wdata, working_data;
   logic mem_re, mem_we, working_we, carry_we, carry_out, busy, done;
   logic [31:0] rng = 32'h00009816;
   int n_fail = 0, checks = 0;
   logic [7:0] corner [4] = '{8'h00, 8'hFF, 8'h80, 8'h01};

   always #5 mclk = ~mclk;

   byte_rotate_unit dut (.mclk(mclk), .rst(rst), .ce(ce), .start(start), .op(op),
      .addr(addr), .carry_in(carry_in), .mem_rdata(mem_rdata), .mem_re(mem_re),
      .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
      .working_we(working_we), .working_data(working_data), .carry_we(carry_we),
      .carry_out(carry_out), .busy(busy), .done(done));

   rot_mem mem_i (.mclk(mclk), .ce(ce), .mem_re(mem_re), .mem_we(mem_we), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   // returns {carry, result}
   function automatic logic [8:0] rot(input logic [2:0] o, input logic [7:0] v, input logic c);
      case (o)
         3'h0: return {c, v[6:0], v[7]};
         3'h1, 3'h2: return {v, c};
         3'h3, 3'h4: return {c, v[0], v[7:1]};
         3'h5: return {v[0], c, v[7:1]};
         default: return {c, v};
      endcase
   endfunction

   task automatic check(input logic ok, input string m);
      checks++;
      if (ok !== 1'b1) begin
         n_fail++;
         $display("[ERR] %0t %s", $time, m);
      end
   endtask

   task automatic summarize();
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic run(input logic [2:0] o, input logic [7:0] a, input logic c, input logic fz);
      logic [7:0] old;
      logic [8:0] e;
      logic wk;
      logic cy;
      int n;
      int k;
      old = mem_i.mem[a];
      e = rot(o, old, c);
      wk = (o == 3'h0 || o == 3'h2 || o == 3'h4);
      cy = (o == 3'h1 || o == 3'h2 || o == 3'h5);
      op = rot_op_t'(o);
      addr = a;
      carry_in = c;
      start = 1'b1;
      n = 0;
      k = 0;
      do begin
         @(negedge mclk);
         // only enabled edges advance the rotate; start stands until one takes it
         if (ce) begin
            start = 1'b0;
            n++;
         end
         k++;
         rng = xs(rng);
         ce = !(fz && done !== 1'b1 && rng[1:0] == 2'h0);
         if (n > 0 && done !== 1'b1)
            check(busy === 1'b1 && mem_re === (n == 1) && mem_addr === a, "read phase");
      end while (done !== 1'b1 && k < 40);
      check(n == 3, "done latency");
      check(busy === 1'b0, "busy after done");
      if (done !== 1'b1)
         summarize();
      check(wk ? (working_we === 1'b1 && working_data === e[7:0] && mem_we === 1'b0)
         : (mem_we === 1'b1 && mem_wdata === e[7:0] && working_we === 1'b0), "result");
      check(carry_we === cy && (!cy || carry_out === e[8]), "carry flag");
      @(negedge mclk);
      check(mem_i.mem[a] === (wk ? old : e[7:0]), "memory content");
   endtask

   initial begin
      repeat (16) @(negedge mclk);
      rst = 1'b0;
      // every op against the bit-edge corner values, both carry states
      for (int o = 0; o < 8; o++) begin
         for (int k = 0; k < 8; k++) begin
            mem_i.mem[8'(k)] = corner[k % 4];
            run(3'(o), 8'(k), k[2], 1'b0);
         end
      end
      // reset in mid-rotate must abort it and clear every strobe and held value
      op = rotate_right_in_place;
      addr = 8'h10;
      start = 1'b1;
      @(negedge mclk);
      start = 1'b0;
      @(negedge mclk);
      rst = 1'b1;
      @(negedge mclk);
      check({busy, done, mem_re, mem_we, working_we, carry_we} === 6'h00, "reset strobes");
      check({carry_out, mem_addr, working_data, mem_wdata} === 25'h0000000, "reset data");
      rst = 1'b0;
      for (int i = 0; i < 200; i++) begin
         rng = xs(rng);
         run(3'(rng[10:8] % 3'h6), rng[7:0], rng[16], rng[20]);
      end
      summarize();
   end
endmodule
